// ### core/msor_fill_watch.v
// Fill threshold watch: status flag and interrupt pin drive.
`include "msor_defines.vh"

module msor_fill_watch #(
  parameter PULSE_CYCLES = `MSOR_PULSE_CYCLES
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Threshold and FIFO state
  input wire [9:0] fill_threshold,
  input wire [15:0] fifo_byte_count,
  input wire fifo_read_active,
  input wire fifo_first_read,
  // Pin mode
  input wire int_latch_mode,
  // Results
  output reg fill_threshold_flag_r,
  output reg int_level_r
);

  // ----------------------------------------------------------------------
  // Flag
  // ----------------------------------------------------------------------
  reg fill_threshold_flag_nxt;
  reg [`MSOR_CNT_W-1:0] pulse_cnt_r;
  reg [`MSOR_CNT_W-1:0] pulse_cnt_nxt;
  reg int_level_nxt;
  wire over_level;
  wire set_cond;
  wire rise;

  assign over_level = fifo_byte_count >= {6'h00, fill_threshold};
  // A zero threshold blocks the set condition, so the flag never sets.
  assign set_cond = over_level && !fifo_read_active &&
                    (fill_threshold != `MSOR_TH_ZERO);
  assign rise = set_cond && !fill_threshold_flag_r;

  always @* begin
    fill_threshold_flag_nxt = fill_threshold_flag_r;
    // Set wins over the read clear, so a late event is never lost.
    if (set_cond) begin
      fill_threshold_flag_nxt = 1'b1;
    end else if (fifo_first_read) begin
      fill_threshold_flag_nxt = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt pin
  // ----------------------------------------------------------------------
  always @* begin
    pulse_cnt_nxt = pulse_cnt_r;
    int_level_nxt = int_level_r;
    if (int_latch_mode) begin
      pulse_cnt_nxt = `MSOR_CNT_ZERO;
      int_level_nxt = fill_threshold_flag_nxt;
    end else if (rise) begin
      pulse_cnt_nxt = PULSE_CYCLES[`MSOR_CNT_W-1:0] - `MSOR_CNT_ONE;
      int_level_nxt = 1'b1;
    end else if (pulse_cnt_r != `MSOR_CNT_ZERO) begin
      pulse_cnt_nxt = pulse_cnt_r - `MSOR_CNT_ONE;
    end else begin
      int_level_nxt = 1'b0;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      fill_threshold_flag_r <= 1'b0;
      pulse_cnt_r <= `MSOR_CNT_ZERO;
      int_level_r <= 1'b0;
    end else begin
      fill_threshold_flag_r <= fill_threshold_flag_nxt;
      pulse_cnt_r <= pulse_cnt_nxt;
      int_level_r <= int_level_nxt;
    end
  end

endmodule

// ### core/msor_regs.v
// Motion sensor output register bank with fill threshold watch.
//
// Overview of operation
// - Temperature result readable as upper byte at 0x41, lower at 0x42.
// - Temperature counts are 326.8 per degree with 25 degree offset.
// - Rate results readable upper first: X 0x43/44, Y 0x45/46, Z 0x47/48.
// - Rate results equal rate times sensitivity, 131 counts per dps at scale 0.
// - Factory check codes for X, Y, Z at 0x50-0x52, read and write.
// - Bits 1:0 at 0x60 hold threshold bits 9:8, reset zero.
// - A zero threshold never raises the fill threshold interrupt.
// - Threshold bits 7:0 live at 0x61, reset zero.
// - Flag sets when count reaches threshold outside a FIFO read; latched pin follows, else pin pulses PULSE_CYCLES cycles.
// - First FIFO data read clears flag and latched pin; re-set afterwards.
`include "msor_defines.vh"

module msor_regs #(
  parameter PULSE_CYCLES = `MSOR_PULSE_CYCLES
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Register port
  input wire [7:0] reg_addr,
  input wire reg_wr_en,
  input wire [7:0] reg_wdata,
  input wire reg_rd_en,
  output reg [7:0] reg_rdata_r,
  output reg reg_rvalid_r,
  // Sensor samples
  input wire sample_valid,
  input wire [15:0] temp_sample,
  input wire [15:0] rate_x_sample,
  input wire [15:0] rate_y_sample,
  input wire [15:0] rate_z_sample,
  // FIFO state
  input wire [15:0] fifo_byte_count,
  input wire fifo_read_active,
  input wire fifo_first_read,
  // Interrupt pin mode
  input wire int_latch_mode,
  // Outputs
  output reg [9:0] fill_threshold_r,
  output reg fill_threshold_flag_r,
  output reg int_out_r
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  reg [7:0] rate_x_factory_code_r;
  reg [7:0] rate_y_factory_code_r;
  reg [7:0] rate_z_factory_code_r;
  reg [1:0] th_upper_r;
  reg [7:0] th_lower_r;
  reg pair_hold_r;
  reg pair_hold_nxt;
  reg [7:0] rdata_nxt;
  wire [15:0] temp_result;
  wire [15:0] rate_x_result;
  wire [15:0] rate_y_result;
  wire [15:0] rate_z_result;
  wire flag_w;
  wire int_w;
  wire is_upper_read;
  wire is_lower_read;

  // ----------------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------------
  function is_upper;
    input [7:0] a;
    begin
      is_upper = (a == `MSOR_ADDR_TEMP_UPPER) ||
                 (a == `MSOR_ADDR_RX_UPPER) ||
                 (a == `MSOR_ADDR_RY_UPPER) ||
                 (a == `MSOR_ADDR_RZ_UPPER);
    end
  endfunction

  function is_lower;
    input [7:0] a;
    begin
      is_lower = (a == `MSOR_ADDR_TEMP_LOWER) ||
                 (a == `MSOR_ADDR_RX_LOWER) ||
                 (a == `MSOR_ADDR_RY_LOWER) ||
                 (a == `MSOR_ADDR_RZ_LOWER);
    end
  endfunction

  assign is_upper_read = reg_rd_en && is_upper(reg_addr);
  assign is_lower_read = reg_rd_en && is_lower(reg_addr);

  // ----------------------------------------------------------------------
  // Result holding registers
  // ----------------------------------------------------------------------
  msor_result_capture u_capture (
    .clock(clock),
    .rst(rst),
    .sample_valid(sample_valid),
    .temp_sample(temp_sample),
    .rate_x_sample(rate_x_sample),
    .rate_y_sample(rate_y_sample),
    .rate_z_sample(rate_z_sample),
    .hold(pair_hold_r || is_upper_read),
    .temp_result_r(temp_result),
    .rate_x_result_r(rate_x_result),
    .rate_y_result_r(rate_y_result),
    .rate_z_result_r(rate_z_result)
  );

  // ----------------------------------------------------------------------
  // Byte pair coherence
  // ----------------------------------------------------------------------
  // Reading an upper byte freezes the results until a lower byte is read,
  // so both halves of one value come from the same sample. The cost is
  // that samples arriving in between are dropped.
  always @* begin
    pair_hold_nxt = pair_hold_r;
    if (is_upper_read) begin
      pair_hold_nxt = 1'b1;
    end else if (is_lower_read) begin
      pair_hold_nxt = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------------
  always @(posedge clock) begin
    if (rst) begin
      rate_x_factory_code_r <= `MSOR_CODE_RST;
      rate_y_factory_code_r <= `MSOR_CODE_RST;
      rate_z_factory_code_r <= `MSOR_CODE_RST;
      th_upper_r <= `MSOR_TH_UPPER_RST;
      th_lower_r <= `MSOR_TH_LOWER_RST;
    end else if (reg_wr_en) begin
      case (reg_addr)
        `MSOR_ADDR_X_CODE: begin
          rate_x_factory_code_r <= reg_wdata;
        end
        `MSOR_ADDR_Y_CODE: begin
          rate_y_factory_code_r <= reg_wdata;
        end
        `MSOR_ADDR_Z_CODE: begin
          rate_z_factory_code_r <= reg_wdata;
        end
        `MSOR_ADDR_TH_UPPER: begin
          th_upper_r <= reg_wdata[`MSOR_TH_UPPER_MSB:0];
        end
        `MSOR_ADDR_TH_LOWER: begin
          th_lower_r <= reg_wdata;
        end
        default: begin
          th_lower_r <= th_lower_r;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------------
  // Result registers ignore writes; unmapped addresses read zero.
  always @* begin
    case (reg_addr)
      `MSOR_ADDR_TEMP_UPPER: rdata_nxt = temp_result[15:8];
      `MSOR_ADDR_TEMP_LOWER: rdata_nxt = temp_result[7:0];
      `MSOR_ADDR_RX_UPPER: rdata_nxt = rate_x_result[15:8];
      `MSOR_ADDR_RX_LOWER: rdata_nxt = rate_x_result[7:0];
      `MSOR_ADDR_RY_UPPER: rdata_nxt = rate_y_result[15:8];
      `MSOR_ADDR_RY_LOWER: rdata_nxt = rate_y_result[7:0];
      `MSOR_ADDR_RZ_UPPER: rdata_nxt = rate_z_result[15:8];
      `MSOR_ADDR_RZ_LOWER: rdata_nxt = rate_z_result[7:0];
      `MSOR_ADDR_X_CODE: rdata_nxt = rate_x_factory_code_r;
      `MSOR_ADDR_Y_CODE: rdata_nxt = rate_y_factory_code_r;
      `MSOR_ADDR_Z_CODE: rdata_nxt = rate_z_factory_code_r;
      `MSOR_ADDR_TH_UPPER: rdata_nxt = {`MSOR_TH_UPPER_PAD, th_upper_r};
      `MSOR_ADDR_TH_LOWER: rdata_nxt = th_lower_r;
      default: rdata_nxt = `MSOR_BYTE_ZERO;
    endcase
  end

  // ----------------------------------------------------------------------
  // Fill threshold watch
  // ----------------------------------------------------------------------
  msor_fill_watch #(
    .PULSE_CYCLES(PULSE_CYCLES)
  ) u_watch (
    .clock(clock),
    .rst(rst),
    .fill_threshold({th_upper_r, th_lower_r}),
    .fifo_byte_count(fifo_byte_count),
    .fifo_read_active(fifo_read_active),
    .fifo_first_read(fifo_first_read),
    .int_latch_mode(int_latch_mode),
    .fill_threshold_flag_r(flag_w),
    .int_level_r(int_w)
  );

  // ----------------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------------
  // Flag and pin pass one more stage so every output leaves a flip-flop
  // of this module.
  always @(posedge clock) begin
    if (rst) begin
      reg_rdata_r <= `MSOR_BYTE_ZERO;
      reg_rvalid_r <= 1'b0;
      pair_hold_r <= 1'b0;
      fill_threshold_r <= `MSOR_TH_ZERO;
      fill_threshold_flag_r <= 1'b0;
      int_out_r <= 1'b0;
    end else begin
      reg_rvalid_r <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rdata_r <= rdata_nxt;
      end
      pair_hold_r <= pair_hold_nxt;
      fill_threshold_r <= {th_upper_r, th_lower_r};
      fill_threshold_flag_r <= flag_w;
      int_out_r <= int_w;
    end
  end

endmodule

// ### core/msor_result_capture.v
// Holding registers for the temperature and angular-rate results.
`include "msor_defines.vh"

module msor_result_capture (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Samples from the conversion logic
  input wire sample_valid,
  input wire [15:0] temp_sample,
  input wire [15:0] rate_x_sample,
  input wire [15:0] rate_y_sample,
  input wire [15:0] rate_z_sample,
  // Holds the results while the host reads a byte pair
  input wire hold,
  // Held results
  output reg [15:0] temp_result_r,
  output reg [15:0] rate_x_result_r,
  output reg [15:0] rate_y_result_r,
  output reg [15:0] rate_z_result_r
);

  // ----------------------------------------------------------------------
  // Capture
  // ----------------------------------------------------------------------
  // A sample that arrives during a hold is dropped; the next one lands.
  always @(posedge clock) begin
    if (rst) begin
      temp_result_r <= `MSOR_WORD_ZERO;
      rate_x_result_r <= `MSOR_WORD_ZERO;
      rate_y_result_r <= `MSOR_WORD_ZERO;
      rate_z_result_r <= `MSOR_WORD_ZERO;
    end else if (sample_valid && !hold) begin
      temp_result_r <= temp_sample;
      rate_x_result_r <= rate_x_sample;
      rate_y_result_r <= rate_y_sample;
      rate_z_result_r <= rate_z_sample;
    end
  end

endmodule

// ### include/msor_defines.vh
// Constants for the motion sensor output register bank.
`ifndef MSOR_DEFINES_VH
`define MSOR_DEFINES_VH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define MSOR_ADDR_TEMP_UPPER 8'h41
`define MSOR_ADDR_TEMP_LOWER 8'h42
`define MSOR_ADDR_RX_UPPER 8'h43
`define MSOR_ADDR_RX_LOWER 8'h44
`define MSOR_ADDR_RY_UPPER 8'h45
`define MSOR_ADDR_RY_LOWER 8'h46
`define MSOR_ADDR_RZ_UPPER 8'h47
`define MSOR_ADDR_RZ_LOWER 8'h48
`define MSOR_ADDR_X_CODE 8'h50
`define MSOR_ADDR_Y_CODE 8'h51
`define MSOR_ADDR_Z_CODE 8'h52
`define MSOR_ADDR_TH_UPPER 8'h60
`define MSOR_ADDR_TH_LOWER 8'h61

// ----------------------------------------------------------------------
// Field layouts and reset values
// ----------------------------------------------------------------------
`define MSOR_TH_UPPER_MSB 1
`define MSOR_TH_UPPER_PAD 6'h00
`define MSOR_TH_UPPER_RST 2'h0
`define MSOR_TH_LOWER_RST 8'h00
`define MSOR_TH_ZERO 10'h000
`define MSOR_CODE_RST 8'h00
`define MSOR_BYTE_ZERO 8'h00
`define MSOR_WORD_ZERO 16'h0000

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define MSOR_CLK_PERIOD_NS 10
`define MSOR_PULSE_NS 50000
`define MSOR_PULSE_CYCLES (`MSOR_PULSE_NS / `MSOR_CLK_PERIOD_NS)
`define MSOR_CNT_W 16
`define MSOR_CNT_ZERO 16'h0000
`define MSOR_CNT_ONE 16'h0001

`endif

// ### sim/msor_host.sv
// Host model that drives the register port of the bank.
module msor_host (
  // Clock
  input logic clock,
  // Register port
  output logic [7:0] reg_addr,
  output logic reg_wr_en,
  output logic [7:0] reg_wdata,
  output logic reg_rd_en,
  input logic [7:0] reg_rdata_r,
  input logic reg_rvalid_r
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wdata = 8'h00;
    reg_rd_en = 1'b0;
  end
  // Released lines show the inverse so a stale value cannot pass.
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge clock);
    reg_wr_en <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge clock);
    reg_rd_en <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rvalid_r ? reg_rdata_r : 8'hxx;
  endtask
  // Expected factory measurement for a stored check code.
  function real factory_meas(input int code, input int fs);
    return 2620.0 / (2.0 ** fs) * (1.01 ** (code - 1));
  endfunction
endmodule

// ### sim/msor_regs_sva.sv
// Checker for the motion sensor output register bank.
module msor_regs_sva #(
  parameter PULSE_CYCLES = 5000
) (
  // Clock and reset
  input logic clock,
  input logic rst,
  // Register port
  input logic [7:0] reg_addr,
  input logic reg_rd_en,
  input logic [7:0] reg_rdata_r,
  input logic reg_rvalid_r,
  // Watermark
  input logic [15:0] fifo_byte_count,
  input logic fifo_read_active,
  input logic fifo_first_read,
  input logic int_latch_mode,
  input logic [9:0] fill_threshold_r,
  input logic fill_threshold_flag_r,
  input logic int_out_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic unmapped;
  logic [15:0] hi_cnt_r;
  assign unmapped = !(reg_addr inside
    {[8'h41:8'h48], [8'h50:8'h52], 8'h60, 8'h61});
  // Counts how long the pin has stood high in pulse mode only, so a level
  // left over from latch mode never looks like an overlong pulse.
  always_ff @(posedge clock) begin
    if (rst || !int_out_r || int_latch_mode) hi_cnt_r <= 16'h0000;
    else hi_cnt_r <= hi_cnt_r + 16'h0001;
  end
  sequence s_cond;
    fill_threshold_r != 10'h000 && !fifo_read_active &&
      fifo_byte_count >= {6'h00, fill_threshold_r};
  endsequence
  property p_answer; reg_rd_en |=> reg_rvalid_r; endproperty
  a_answer: assert property (p_answer)
    else $error("read not answered");
  property p_quiet; !reg_rd_en |=> !reg_rvalid_r; endproperty
  a_quiet: assert property (p_quiet)
    else $error("valid without read");
  property p_unmapped; reg_rd_en && unmapped |=> reg_rdata_r == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_pad; reg_rd_en && reg_addr == 8'h60 |=> reg_rdata_r[7:2] == 6'h00;
  endproperty
  a_pad: assert property (p_pad)
    else $error("unused threshold bits set");
  property p_zero; (fill_threshold_r == 10'h000) [*3]
    |=> !$rose(fill_threshold_flag_r); endproperty
  a_zero: assert property (p_zero)
    else $error("flag raised with zero threshold");
  property p_set; s_cond ##1 $stable(fill_threshold_r)
    |=> fill_threshold_flag_r; endproperty
  a_set: assert property (p_set)
    else $error("flag not set");
  property p_clear; fifo_first_read && fifo_read_active
    |-> ##2 !fill_threshold_flag_r; endproperty
  a_clear: assert property (p_clear)
    else $error("flag not cleared");
  property p_latch; int_latch_mode && $past(int_latch_mode) &&
    $past(int_latch_mode, 2) |-> int_out_r == fill_threshold_flag_r;
  endproperty
  a_latch: assert property (p_latch)
    else $error("latched pin differs from flag");
  property p_pulse_len; $fell(int_out_r) && !$past(int_latch_mode) &&
    !$past(int_latch_mode, 2) |-> hi_cnt_r == PULSE_CYCLES; endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("pulse width wrong");
  property p_pulse_max; !int_latch_mode |-> hi_cnt_r <= PULSE_CYCLES;
  endproperty
  a_pulse_max: assert property (p_pulse_max)
    else $error("pulse too long");
endmodule

bind msor_regs msor_regs_sva #(.PULSE_CYCLES(PULSE_CYCLES)) i_sva (
  .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_rd_en(reg_rd_en),
  .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r),
  .fifo_byte_count(fifo_byte_count), .fifo_read_active(fifo_read_active),
  .fifo_first_read(fifo_first_read), .int_latch_mode(int_latch_mode),
  .fill_threshold_r(fill_threshold_r),
  .fill_threshold_flag_r(fill_threshold_flag_r), .int_out_r(int_out_r));

// ### sim/test_msor_regs.sv
// Self-checking testbench for the motion sensor output register bank.
module test_msor_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_r, d;
  logic reg_wr_en, reg_rd_en, reg_rvalid_r, flag, int_out_r;
  logic sample_valid = 1'b0;
  logic [15:0] temp_sample = 16'h0000, rate_x_sample = 16'h0000;
  logic [15:0] rate_y_sample = 16'h0000, rate_z_sample = 16'h0000;
  logic [15:0] fifo_byte_count = 16'h0000;
  logic fifo_read_active = 1'b0, fifo_first_read = 1'b0;
  logic int_latch_mode = 1'b1;
  logic [9:0] th;
  logic [15:0] res[4];
  integer err_count = 0, n_compared = 0, seed = 32'h8bca, cnt;
  always #5 clock = ~clock;
  msor_regs #(.PULSE_CYCLES(8)) i_dut (.clock(clock), .rst(rst),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
    .reg_rd_en(reg_rd_en), .reg_rdata_r(reg_rdata_r),
    .reg_rvalid_r(reg_rvalid_r), .sample_valid(sample_valid),
    .temp_sample(temp_sample), .rate_x_sample(rate_x_sample),
    .rate_y_sample(rate_y_sample), .rate_z_sample(rate_z_sample),
    .fifo_byte_count(fifo_byte_count), .fifo_read_active(fifo_read_active),
    .fifo_first_read(fifo_first_read), .int_latch_mode(int_latch_mode),
    .fill_threshold_r(th), .fill_threshold_flag_r(flag),
    .int_out_r(int_out_r));
  msor_host i_host (.clock(clock), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
    .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r));
  task chk(input string what, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task end_sim;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // A dropped sample leaves the expected results untouched.
  task push(input bit keep);
    logic [15:0] v[4];
    foreach (v[i]) v[i] = $random(seed);
    @(posedge clock);
    {temp_sample, rate_x_sample, rate_y_sample, rate_z_sample} <=
      {v[0], v[1], v[2], v[3]};
    sample_valid <= 1'b1;
    @(posedge clock);
    sample_valid <= 1'b0;
    if (keep) foreach (v[i]) res[i] = v[i];
  endtask
  function logic [7:0] exp_byte(input logic [7:0] a);
    logic [15:0] w;
    w = res[(a - 8'h41) >> 1];
    return a[0] ? w[15:8] : w[7:0];
  endfunction
  initial begin
    repeat (5000) @(posedge clock);
    err_count++;
    end_sim;
  end
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    for (int a = 8'h50; a <= 8'h61; a++) begin
      if (a > 8'h52 && a < 8'h60) continue;
      i_host.rd(a[7:0], d);
      chk("reset value", 16'h0000, {8'h00, d});
    end
    $display("reset values done");
    for (int k = 0; k < 4; k++) begin
      push(1'b1);
      for (int a = 8'h41; a <= 8'h48; a++) begin
        i_host.rd(a[7:0], d);
        chk("result byte", {8'h00, exp_byte(a[7:0])}, {8'h00, d});
      end
    end
    i_host.rd(8'h43, d);
    push(1'b0);
    i_host.rd(8'h44, d);
    chk("held lower byte", {8'h00, exp_byte(8'h44)}, {8'h00, d});
    fork
      i_host.rd(8'h45, d);
      push(1'b0);
    join
    chk("upper with sample", {8'h00, exp_byte(8'h45)}, {8'h00, d});
    i_host.rd(8'h46, d);
    chk("lower with sample", {8'h00, exp_byte(8'h46)}, {8'h00, d});
    $display("results done");
    for (int i = 0; i < 3; i++) begin
      cnt = $random(seed);
      i_host.wr(8'h50 + i[7:0], cnt[7:0]);
      i_host.rd(8'h50 + i[7:0], d);
      chk("check code", {8'h00, cnt[7:0]}, {8'h00, d});
    end
    i_host.wr(8'h41, ~exp_byte(8'h41));
    i_host.rd(8'h41, d);
    chk("read-only byte", {8'h00, exp_byte(8'h41)}, {8'h00, d});
    i_host.rd(8'h7f, d);
    chk("unmapped", 16'h0000, {8'h00, d});
    i_host.wr(8'h60, 8'hff);
    i_host.rd(8'h60, d);
    chk("upper threshold", 16'h0003, {8'h00, d});
    i_host.wr(8'h60, 8'h00);
    i_host.wr(8'h51, 8'h02);
    i_host.rd(8'h51, d);
    chk("factory", 16'h052b, 16'(int'(i_host.factory_meas(d, 1))));
    $display("codes done");
    @(posedge clock);
    fifo_byte_count <= 16'hffff;
    tick(6);
    chk("zero threshold flag", 16'h0000, {15'h0, flag});
    // The count is parked low while the two threshold halves are written,
    // since a half-written threshold would already trip the flag.
    @(posedge clock);
    fifo_byte_count <= 16'h0000;
    i_host.wr(8'h60, 8'h01);
    i_host.wr(8'h61, 8'h05);
    @(posedge clock);
    fifo_byte_count <= 16'h0104;
    tick(4);
    chk("threshold", 16'h0105, {6'h00, th});
    chk("below threshold", 16'h0000, {15'h0, flag});
    @(posedge clock);
    fifo_byte_count <= 16'h0105;
    tick(4);
    chk("flag and pin", 16'h0003, {14'h0, flag, int_out_r});
    @(posedge clock);
    fifo_read_active <= 1'b1;
    fifo_first_read <= 1'b1;
    @(posedge clock);
    fifo_first_read <= 1'b0;
    tick(3);
    chk("cleared", 16'h0000, {14'h0, flag, int_out_r});
    @(posedge clock);
    fifo_read_active <= 1'b0;
    tick(4);
    chk("set again", 16'h0003, {14'h0, flag, int_out_r});
    @(posedge clock);
    fifo_read_active <= 1'b1;
    fifo_first_read <= 1'b1;
    fifo_byte_count <= 16'h0000;
    @(posedge clock);
    fifo_first_read <= 1'b0;
    fifo_read_active <= 1'b0;
    int_latch_mode <= 1'b0;
    tick(4);
    @(posedge clock);
    fifo_byte_count <= 16'h03ff;
    cnt = 0;
    repeat (20) begin
      tick(1);
      if (int_out_r === 1'b1) cnt++;
    end
    chk("pulse width", 16'h0008, cnt[15:0]);
    $display("watermark done");
    end_sim;
  end
endmodule
